// File: hdl/dcc_pkg.sv
// Shared constants and types of the DMA channel controller.
// Assumes an 8-bit register port and a 16-bit byte memory bus.
package dcc_pkg;
  // Register indices on the register port
  localparam logic [3:0] DCC_REG_MODE_ONE = 4'h0;
  localparam logic [3:0] DCC_REG_MODE_TWO = 4'h1;
  localparam logic [3:0] DCC_REG_DEST_LO = 4'h2;
  localparam logic [3:0] DCC_REG_DEST_HI = 4'h3;
  localparam logic [3:0] DCC_REG_SRC_LO = 4'h4;
  localparam logic [3:0] DCC_REG_SRC_HI = 4'h5;
  localparam logic [3:0] DCC_REG_COUNT = 4'h6;
  localparam logic [3:0] DCC_REG_STATUS = 4'h7;
  localparam logic [3:0] DCC_REG_INT_CTRL = 4'h8;

  // channel_mode_one fields
  localparam int DCC_M1_ENABLE = 7;
  localparam int DCC_M1_LATCH_CLR = 6;
  localparam int DCC_M1_HW_DISABLE = 5;
  localparam int DCC_M1_SW_TRIG = 4;
  localparam int DCC_M1_DEST_STEP = 3;
  localparam int DCC_M1_DEST_DOWN = 2;
  localparam int DCC_M1_SRC_STEP = 1;
  localparam int DCC_M1_SRC_DOWN = 0;
  // Bits that store; the latch clear and trigger are actions
  localparam logic [7:0] DCC_M1_STORE_MASK = 8'haf;

  // channel_mode_two: request line select
  localparam int DCC_M2_SEL_W = 3;
  localparam logic [2:0] DCC_SEL_UART_RX = 3'h0;

  // Status fields
  localparam int DCC_ST_UNDERFLOW = 0;
  localparam int DCC_ST_PENDING = 1;
  localparam int DCC_ST_BUSY = 2;

  // interrupt_control_first fields
  localparam int DCC_IC_DMA_EN = 3;
  localparam int DCC_IC_UART_RX_EN = 4;

  // Reset values
  localparam logic [7:0] DCC_MODE_ONE_RST = 8'h00;
  localparam logic [7:0] DCC_MODE_TWO_RST = 8'h00;
  localparam logic [7:0] DCC_INT_CTRL_RST = 8'h00;
  localparam logic [15:0] DCC_ADDR_RST = 16'h0000;
  localparam logic [7:0] DCC_COUNT_RST = 8'h00;

  // Structure defaults
  localparam int DCC_FIFO_DEPTH = 4;
  localparam int DCC_REQ_LINES = 8;

  // One buffered byte with the address it is bound for
  typedef struct packed {
    logic [15:0] dest;
    logic [7:0] data;
  } dcc_word_t;
endpackage : dcc_pkg

// File: hdl/dcc_sync.sv
// Two-stage synchroniser for a group of level inputs.
// Assumes each bit is a slow level, not a bus value.
`timescale 1ns/10ps
module dcc_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_reg;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_reg <= '0;
      sync_out <= '0;
    end else begin
      stage_reg <= async_in;
      sync_out <= stage_reg;
    end
  end
endmodule : dcc_sync

// File: hdl/dcc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; data out is shown from the head entry.
`timescale 1ns/10ps
module dcc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] level_reg;
  logic push;
  logic pop;

  assign in_ready_out = (level_reg != FULL);
  assign out_valid_out = (level_reg != '0);
  assign out_data_out = mem[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end
endmodule : dcc_fifo

// File: hdl/dcc_top.sv
// DMA channel controller: one byte per trigger from source to
// destination, through a small buffer, with count and reload.
// Assumes a same-clock register port and a memory bus that answers
// a read one cycle after its strobe and accepts a write when ready.
//
// Overview of operation
// R01: Hardware requests are taken only while the disable bit is zero.
// R02: Software disables requests, then clears disable and triggers in one write.
// R03: Mode value 08 steps destination by one, source stays fixed.
// R04: Destination is 16 bits, low and high bytes written separately.
// R05: Source is 16 bits in two bytes; each transfer reads from it.
// R06: Eight-bit transfer count decrements once per completed byte.
// R07: Count underflow sets the underflow flag and the DMA interrupt.
// R08: Underflow reloads source, destination and count from last writes.
// R09: Second mode value 00 selects the UART receive request.
// R10: Mode value C8 enables, steps destination, clears the sample latch.
// R11: Each new selected request moves exactly one byte; a request arriving while one is still latched merges into it.
// R12: Interrupt service may reprogram or keep the reloaded values.
// R13: Control bit 3 enables DMA interrupt; bit 4 gates UART CPU interrupt.
// R14: Sample latch holds a request until its transfer is taken.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/10ps
module dcc_top
  import dcc_pkg::*;
#(
  parameter int FIFO_DEPTH = DCC_FIFO_DEPTH,
  parameter int REQ_LINES = DCC_REQ_LINES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [REQ_LINES-1:0] periph_req_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_wr_ready_in,
  output logic dma_irq_out,
  output logic uart_rx_cpu_irq_out
);
  localparam int WORD_W = $bits(dcc_word_t);

  // Software-visible state
  logic [7:0] mode_one_reg;
  logic [7:0] mode_two_reg;
  logic [7:0] int_ctrl_reg;
  logic [15:0] src_shadow_reg;
  logic [15:0] dest_shadow_reg;
  logic [7:0] count_shadow_reg;
  logic [15:0] src_reg;
  logic [15:0] dest_reg;
  logic [7:0] count_reg;
  logic underflow_reg;

  // Request path
  logic [REQ_LINES-1:0] req_sync;
  logic req_sel;
  logic req_prev_reg;
  logic req_edge;
  logic latch_reg;

  // Transfer engine
  logic [15:0] dest_hold_reg;
  logic rd_wait_reg;
  logic rd_go;
  logic wr_go;
  logic fifo_in_ready;
  logic fifo_out_valid;
  dcc_word_t fifo_in_word;
  dcc_word_t fifo_out_word;

  // Write decode
  logic wr_mode_one;
  logic wr_mode_two;
  logic wr_dest_lo;
  logic wr_dest_hi;
  logic wr_src_lo;
  logic wr_src_hi;
  logic wr_count;
  logic wr_status;
  logic wr_int_ctrl;
  logic sw_trig;
  logic latch_clr_cmd;
  logic [7:0] rd_mux;

  // Step an address by one in the chosen direction, or hold it
  function automatic logic [15:0] dcc_step(input logic [15:0] addr,
                                           input logic step,
                                           input logic down);
    logic [15:0] r;
    r = addr;
    if (step) begin
      r = down ? addr - 16'h0001 : addr + 16'h0001;
    end
    return r;
  endfunction : dcc_step

  function automatic logic dcc_hit(input logic [3:0] addr,
                                   input logic [3:0] idx,
                                   input logic strobe);
    return strobe && (addr == idx);
  endfunction : dcc_hit

  assign wr_mode_one = dcc_hit(reg_addr_in, DCC_REG_MODE_ONE, reg_wr_in);
  assign wr_mode_two = dcc_hit(reg_addr_in, DCC_REG_MODE_TWO, reg_wr_in);
  assign wr_dest_lo = dcc_hit(reg_addr_in, DCC_REG_DEST_LO, reg_wr_in);
  assign wr_dest_hi = dcc_hit(reg_addr_in, DCC_REG_DEST_HI, reg_wr_in);
  assign wr_src_lo = dcc_hit(reg_addr_in, DCC_REG_SRC_LO, reg_wr_in);
  assign wr_src_hi = dcc_hit(reg_addr_in, DCC_REG_SRC_HI, reg_wr_in);
  assign wr_count = dcc_hit(reg_addr_in, DCC_REG_COUNT, reg_wr_in);
  assign wr_status = dcc_hit(reg_addr_in, DCC_REG_STATUS, reg_wr_in);
  assign wr_int_ctrl = dcc_hit(reg_addr_in, DCC_REG_INT_CTRL, reg_wr_in);

  // R02 trigger and re-enable arrive in one write
  assign sw_trig = wr_mode_one && reg_wdata_in[DCC_M1_SW_TRIG];
  // R10 latch clear on a mode write
  assign latch_clr_cmd = wr_mode_one && reg_wdata_in[DCC_M1_LATCH_CLR];

  // Request lines may come from other clock regions
  dcc_sync #(
    .WIDTH(REQ_LINES)
  ) u_req_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(periph_req_in),
    .sync_out(req_sync)
  );

  // R09 line select, zero is the UART receive request
  always_comb begin
    req_sel = 1'b0;
    if (32'(mode_two_reg[DCC_M2_SEL_W-1:0]) < REQ_LINES) begin
      req_sel = req_sync[mode_two_reg[DCC_M2_SEL_W-1:0]];
    end
  end

  // R01 hardware edges masked while requests are disabled
  assign req_edge = req_sel && !req_prev_reg &&
                    !mode_one_reg[DCC_M1_HW_DISABLE];

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_prev_reg <= 1'b0;
    end else begin
      req_prev_reg <= req_sel;
    end
  end

  // R14 sample latch; a new request beats any clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_reg <= 1'b0;
    end else if (req_edge || sw_trig) begin
      latch_reg <= 1'b1;
    end else if (rd_go || latch_clr_cmd) begin
      latch_reg <= 1'b0;
    end
  end

  // Mode and interrupt control registers
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_one_reg <= DCC_MODE_ONE_RST;
      mode_two_reg <= DCC_MODE_TWO_RST;
      int_ctrl_reg <= DCC_INT_CTRL_RST;
    end else begin
      if (wr_mode_one) begin
        mode_one_reg <= reg_wdata_in & DCC_M1_STORE_MASK;
      end
      if (wr_mode_two) begin
        mode_two_reg <= reg_wdata_in;
      end
      if (wr_int_ctrl) begin
        int_ctrl_reg <= reg_wdata_in;
      end
    end
  end

  // Shadow copies keep the last written values for reload
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_shadow_reg <= DCC_ADDR_RST;
      dest_shadow_reg <= DCC_ADDR_RST;
      count_shadow_reg <= DCC_COUNT_RST;
    end else begin
      if (wr_src_lo) begin
        src_shadow_reg[7:0] <= reg_wdata_in;
      end
      if (wr_src_hi) begin
        src_shadow_reg[15:8] <= reg_wdata_in;
      end
      if (wr_dest_lo) begin
        dest_shadow_reg[7:0] <= reg_wdata_in;
      end
      if (wr_dest_hi) begin
        dest_shadow_reg[15:8] <= reg_wdata_in;
      end
      if (wr_count) begin
        count_shadow_reg <= reg_wdata_in;
      end
    end
  end

  // Arbitration: a buffered write goes first so the buffer drains;
  // a read is started only with room for its byte and none in flight.
  assign wr_go = fifo_out_valid && mem_wr_ready_in;
  // R11 one read per latched request
  assign rd_go = latch_reg && mode_one_reg[DCC_M1_ENABLE] &&
                 fifo_in_ready && !mem_rd_out && !rd_wait_reg && !wr_go;

  // Live source address
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_reg <= DCC_ADDR_RST;
    end else if (wr_src_lo || wr_src_hi) begin
      // R05 byte halves written separately
      if (wr_src_lo) begin
        src_reg[7:0] <= reg_wdata_in;
      end
      if (wr_src_hi) begin
        src_reg[15:8] <= reg_wdata_in;
      end
    end else if (wr_go && count_reg == 8'h00) begin
      // R08 reload source
      src_reg <= src_shadow_reg;
    end else if (rd_go) begin
      // R03 source steps only if asked
      src_reg <= dcc_step(src_reg, mode_one_reg[DCC_M1_SRC_STEP],
                          mode_one_reg[DCC_M1_SRC_DOWN]);
    end
  end

  // Live destination address
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dest_reg <= DCC_ADDR_RST;
    end else if (wr_dest_lo || wr_dest_hi) begin
      // R04 byte halves written separately
      if (wr_dest_lo) begin
        dest_reg[7:0] <= reg_wdata_in;
      end
      if (wr_dest_hi) begin
        dest_reg[15:8] <= reg_wdata_in;
      end
    end else if (wr_go && count_reg == 8'h00) begin
      // R08 reload destination
      dest_reg <= dest_shadow_reg;
    end else if (rd_go) begin
      // R03 destination step by one
      dest_reg <= dcc_step(dest_reg, mode_one_reg[DCC_M1_DEST_STEP],
                           mode_one_reg[DCC_M1_DEST_DOWN]);
    end
  end

  // Transfer count, counted on completed writes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= DCC_COUNT_RST;
    end else if (wr_count) begin
      count_reg <= reg_wdata_in;
    end else if (wr_go) begin
      // R08 reload count on underflow
      if (count_reg == 8'h00) begin
        count_reg <= count_shadow_reg;
      end else begin
        // R06 decrement per byte
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // R07 underflow flag; setting wins over a write-one clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      underflow_reg <= 1'b0;
    end else if (wr_go && count_reg == 8'h00) begin
      underflow_reg <= 1'b1;
    end else if (wr_status && reg_wdata_in[DCC_ST_UNDERFLOW]) begin
      underflow_reg <= 1'b0;
    end
  end

  // Read side of the memory bus: strobe, then data one cycle later
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_wait_reg <= 1'b0;
      dest_hold_reg <= DCC_ADDR_RST;
    end else begin
      rd_wait_reg <= mem_rd_out;
      if (rd_go) begin
        dest_hold_reg <= dest_reg;
      end
    end
  end

  // R05 read from the live source address
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_addr_out <= DCC_ADDR_RST;
      mem_rd_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_wdata_out <= 8'h00;
    end else begin
      mem_rd_out <= rd_go;
      mem_wr_out <= wr_go;
      if (wr_go) begin
        mem_addr_out <= fifo_out_word.dest;
        mem_wdata_out <= fifo_out_word.data;
      end else if (rd_go) begin
        mem_addr_out <= src_reg;
      end
    end
  end

  assign fifo_in_word.dest = dest_hold_reg;
  assign fifo_in_word.data = mem_rdata_in;

  // Room is checked before the read, so the push is never refused
  dcc_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(rd_wait_reg),
    .in_ready_out(fifo_in_ready),
    .in_data_in(fifo_in_word),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(wr_go),
    .out_data_out(fifo_out_word)
  );

  // Interrupt lines toward the CPU interrupt logic
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dma_irq_out <= 1'b0;
      uart_rx_cpu_irq_out <= 1'b0;
    end else begin
      // R07 interrupt follows the flag
      // R13 gated by control bit 3
      dma_irq_out <= underflow_reg && int_ctrl_reg[DCC_IC_DMA_EN];
      // R13 UART CPU interrupt gated by bit 4, DMA still sees it
      uart_rx_cpu_irq_out <= req_sync[0] &&
                             int_ctrl_reg[DCC_IC_UART_RX_EN];
    end
  end

  // Register read mux; unmapped indices read zero
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr_in)
      DCC_REG_MODE_ONE: rd_mux = mode_one_reg;
      DCC_REG_MODE_TWO: rd_mux = mode_two_reg;
      DCC_REG_DEST_LO: rd_mux = dest_reg[7:0];
      DCC_REG_DEST_HI: rd_mux = dest_reg[15:8];
      DCC_REG_SRC_LO: rd_mux = src_reg[7:0];
      DCC_REG_SRC_HI: rd_mux = src_reg[15:8];
      DCC_REG_COUNT: rd_mux = count_reg;
      DCC_REG_STATUS: begin
        rd_mux[DCC_ST_UNDERFLOW] = underflow_reg;
        rd_mux[DCC_ST_PENDING] = latch_reg;
        rd_mux[DCC_ST_BUSY] = fifo_out_valid || mem_rd_out ||
                              rd_wait_reg;
      end
      DCC_REG_INT_CTRL: rd_mux = int_ctrl_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule : dcc_top

// File: testbench/dcc_top_chk.sv
// Port checker for dcc_top, bound to every instance.
// Assumes one clock domain and the FIFO depth of the instance.
`timescale 1ns/10ps
module dcc_top_chk
  import dcc_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int REQ_LINES = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic [REQ_LINES-1:0] periph_req_in,
  input wire logic [15:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_wr_out,
  input wire logic [7:0] mem_wdata_out,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_wr_ready_in,
  input wire logic dma_irq_out,
  input wire logic uart_rx_cpu_irq_out
);
  // Bytes read but not yet written; catches lost or invented writes
  logic [3:0] inflight_reg;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      inflight_reg <= 4'h0;
    end else if (mem_rd_out && !mem_wr_out) begin
      inflight_reg <= inflight_reg + 4'h1;
    end else if (mem_wr_out && !mem_rd_out) begin
      inflight_reg <= inflight_reg - 4'h1;
    end
  end

  sequence rd_then_ready;
    mem_rd_out ##1 mem_wr_ready_in [*3];
  endsequence

  strobe_excl_a: assert property (!(mem_rd_out && mem_wr_out))
    else $error("memory read and write strobes together");
  rd_spacing_a: assert property (mem_rd_out |=> !mem_rd_out [*2])
    else $error("memory reads closer than three cycles");
  wr_has_rd_a: assert property (mem_wr_out |-> inflight_reg != 4'h0)
    else $error("write without a matching read");
  fifo_bound_a: assert property (inflight_reg <= FIFO_DEPTH + 1)
    else $error("more bytes held than the buffer allows");
  wr_follows_a: assert property (rd_then_ready |-> ##[0:2] mem_wr_out)
    else $error("read byte not written while ready");
  stall_hold_a: assert property (!mem_wr_ready_in |=> !mem_wr_out)
    else $error("write issued while memory stalled");
  irq_cause_a: assert property ($rose(dma_irq_out) |->
    $past(mem_wr_out) || $past(reg_wr_in, 2))
    else $error("dma interrupt rose without a write");
  uart_gate_a: assert property (uart_rx_cpu_irq_out |->
    $past(periph_req_in[0], 2) || $past(periph_req_in[0], 3))
    else $error("uart cpu interrupt without request");
  rdata_idle_a: assert property (!$past(reg_rd_in) |->
    reg_rdata_out == 8'h00)
    else $error("read data outside the answer cycle");
endmodule : dcc_top_chk

bind dcc_top dcc_top_chk #(.FIFO_DEPTH(FIFO_DEPTH), .REQ_LINES(REQ_LINES))
  i_dcc_top_chk (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .periph_req_in(periph_req_in),
  .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
  .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
  .mem_rdata_in(mem_rdata_in), .mem_wr_ready_in(mem_wr_ready_in),
  .dma_irq_out(dma_irq_out), .uart_rx_cpu_irq_out(uart_rx_cpu_irq_out));

// File: testbench/dcc_mem_model.sv
// Memory partner for the DMA channel: answers reads, logs writes.
// Assumes read data is wanted in the cycle after the read strobe.
`timescale 1ns/10ps
module dcc_mem_model (
  input wire logic core_clk_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic mem_rd_in,
  input wire logic mem_wr_in,
  input wire logic [7:0] mem_wdata_in,
  input wire logic stall_in,
  output logic [7:0] mem_rdata_out,
  output logic mem_wr_ready_out
);
  logic [7:0] mem [0:65535];
  logic [23:0] wr_log [$];
  initial mem_rdata_out = 8'h00;
  assign mem_wr_ready_out = !stall_in;
  // Outside the answer cycle the bus toggles, so stale data never passes
  always @(posedge core_clk_in) begin
    if (mem_rd_in) begin
      mem_rdata_out <= mem[mem_addr_in];
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
      wr_log.push_back({mem_addr_in, mem_wdata_in});
    end
  end
endmodule : dcc_mem_model

// File: testbench/dcc_top_test.sv
// Self-checking bench for dcc_top with the memory partner.
// Assumes request line 0 is the UART receive request.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s expected %h seen %h", nm, e, g); end end
module dcc_top_test
  import dcc_pkg::*;
;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] periph_req_in = 8'h00;
  logic stall = 1'b0;
  logic [7:0] reg_rdata_out, mem_wdata_out, mem_rdata_in, rd_val;
  logic [15:0] mem_addr_out;
  logic mem_rd_out, mem_wr_out, mem_wr_ready_in, dma_irq_out, uart_irq;
  int fails = 0;
  int samples_checked = 0;

  dcc_top #(.FIFO_DEPTH(4), .REQ_LINES(8)) i_dcc_top (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .periph_req_in(periph_req_in),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
    .mem_rdata_in(mem_rdata_in), .mem_wr_ready_in(mem_wr_ready_in),
    .dma_irq_out(dma_irq_out), .uart_rx_cpu_irq_out(uart_irq));
  dcc_mem_model i_dcc_mem_model (
    .core_clk_in(core_clk_in), .mem_addr_in(mem_addr_out),
    .mem_rd_in(mem_rd_out), .mem_wr_in(mem_wr_out),
    .mem_wdata_in(mem_wdata_out), .stall_in(stall),
    .mem_rdata_out(mem_rdata_in), .mem_wr_ready_out(mem_wr_ready_in));

  initial forever #5 core_clk_in = ~core_clk_in;

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask : reg_read

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] e,
                            input string nm);
    logic [7:0] d;
    reg_read(a, d);
    `CHK(nm, e, d)
  endtask : expect_reg

  // Held four cycles so the synchroniser cannot miss it
  task automatic pulse_req(input logic [7:0] data);
    i_dcc_mem_model.mem[16'h003c] = data;
    @(posedge core_clk_in);
    periph_req_in[0] <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    periph_req_in[0] <= 1'b0;
    repeat (6) @(posedge core_clk_in);
  endtask : pulse_req

  task automatic wait_wr(input int n);
    for (int k = 0; k < 100 && i_dcc_mem_model.wr_log.size() < n; k++) begin
      @(posedge core_clk_in);
    end
    #1;
  endtask : wait_wr

  task automatic t_reset;
    for (int a = 0; a < 9; a++) begin
      expect_reg(a[3:0], 8'h00, "reset value");
    end
    reg_write(4'hf, 8'h5a);
    expect_reg(4'hf, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_stream;
    logic [23:0] ew;
    reg_write(DCC_REG_MODE_TWO, 8'h00);
    reg_write(DCC_REG_DEST_LO, 8'h00);
    reg_write(DCC_REG_DEST_HI, 8'h03);
    reg_write(DCC_REG_SRC_LO, 8'h3c);
    reg_write(DCC_REG_SRC_HI, 8'h00);
    reg_write(DCC_REG_COUNT, 8'h02);
    reg_write(DCC_REG_INT_CTRL, 8'h08);
    reg_write(DCC_REG_MODE_ONE, 8'hc8);
    expect_reg(DCC_REG_MODE_ONE, 8'h88, "mode one");
    for (int i = 0; i < 4; i++) begin
      pulse_req(8'h50 + i[7:0]);
      wait_wr(i + 1);
      ew = {16'h0300 + 16'(i % 3), 8'h50 + i[7:0]};
      `CHK("write", ew, i_dcc_mem_model.wr_log[i])
      if (i == 0) expect_reg(DCC_REG_COUNT, 8'h01, "count");
      if (i == 2) begin
        expect_reg(DCC_REG_STATUS, 8'h01, "status");
        `CHK("dma irq", 1'b1, dma_irq_out)
        expect_reg(DCC_REG_COUNT, 8'h02, "count");
        expect_reg(DCC_REG_DEST_LO, 8'h00, "dest low");
        expect_reg(DCC_REG_SRC_LO, 8'h3c, "src low");
        reg_write(DCC_REG_STATUS, 8'h01);
        expect_reg(DCC_REG_STATUS, 8'h00, "status");
        `CHK("dma irq", 1'b0, dma_irq_out)
      end
    end
  endtask : t_stream

  task automatic t_hw_disable;
    reg_write(DCC_REG_MODE_ONE, 8'ha8);
    pulse_req(8'h71);
    repeat (20) @(posedge core_clk_in);
    `CHK("log size", 4, i_dcc_mem_model.wr_log.size())
    reg_write(DCC_REG_MODE_ONE, 8'h98);
    wait_wr(5);
    `CHK("write", {16'h0301, 8'h71}, i_dcc_mem_model.wr_log[4])
  endtask : t_hw_disable

  task automatic t_stall;
    logic [23:0] ew;
    reg_write(DCC_REG_COUNT, 8'h09);
    reg_write(DCC_REG_DEST_LO, 8'h40);
    stall <= 1'b1;
    for (int i = 0; i < 5; i++) pulse_req(8'h60 + i[7:0]);
    `CHK("log size", 5, i_dcc_mem_model.wr_log.size())
    reg_read(DCC_REG_STATUS, rd_val);
    `CHK("pending", 1'b1, rd_val[DCC_ST_PENDING])
    stall <= 1'b0;
    wait_wr(10);
    for (int i = 0; i < 5; i++) begin
      ew = {16'h0340 + 16'(i), 8'h60 + i[7:0]};
      `CHK("write", ew, i_dcc_mem_model.wr_log[5 + i])
    end
  endtask : t_stall

  task automatic t_uart;
    for (int b = 1; b >= 0; b--) begin
      reg_write(DCC_REG_INT_CTRL, b ? 8'h18 : 8'h08);
      @(posedge core_clk_in);
      periph_req_in[0] <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      #1;
      `CHK("uart irq", b[0], uart_irq)
      @(posedge core_clk_in);
      periph_req_in[0] <= 1'b0;
      repeat (6) @(posedge core_clk_in);
    end
    wait_wr(12);
    `CHK("log size", 12, i_dcc_mem_model.wr_log.size())
  endtask : t_uart

  // A request taken while the channel is off is dropped by the clear
  task automatic t_latch_clr;
    reg_write(DCC_REG_MODE_ONE, 8'h08);
    pulse_req(8'h7e);
    expect_reg(DCC_REG_STATUS, 8'h02, "pending");
    reg_write(DCC_REG_MODE_ONE, 8'h48);
    expect_reg(DCC_REG_STATUS, 8'h00, "cleared");
    reg_write(DCC_REG_MODE_ONE, 8'h88);
    repeat (10) @(posedge core_clk_in);
    `CHK("log size", 12, i_dcc_mem_model.wr_log.size())
  endtask : t_latch_clr

  task automatic close_out;
    if (fails == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_stream();
    t_hw_disable();
    t_stall();
    t_uart();
    t_latch_clr();
    close_out();
  end

  // The whole run needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk_in);
    fails++;
    close_out();
  end
endmodule : dcc_top_test
